// File: src/ddr_bank_term.sv
/*
  Bank boundary registers, termination output select, write-latency
  field check and refresh request for a DDR controller, reached over
  AXI4-Lite. Assumes i_write_active comes from the controller's own
  write sequencer on the same clock.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module ddr_bank_term
  import ddr_term_pkg::*;
#(
  parameter int REFRESH_W = REFRESH_WIDTH
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic        i_write_active,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic             o_termination_out_0,
  output logic             o_termination_out_1,
  output logic             o_mem_type_ddr2,
  output logic [1:0]       o_write_data_latency_field,
  output logic             o_refresh_req
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        res[b*8 +: 8] = new_val[b*8 +: 8];
    end
    return res & mask;
  endfunction : merge_bytes

  logic [31:0]          bank0_boundary;
  logic [31:0]          bank1_boundary;
  logic [31:0]          ddr_control;
  logic [REFRESH_W-1:0] refresh_count;
  logic                 write_refused;
  logic [31:0]          aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 aw_held;
  logic                 w_held;
  logic                 refresh_pulse;
  logic [REFRESH_W-1:0] refresh_now;

  // write path decode
  wire aw_take   = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take    = i_s_axi_wvalid && o_s_axi_wready;
  wire do_write  = aw_held && w_held && !o_s_axi_bvalid;
  wire hit_ctrl  = (aw_addr == ADDR_DDR_CONTROL);
  wire hit_rfsh  = (aw_addr == ADDR_REFRESH_COUNT);
  wire hit_stat  = (aw_addr == ADDR_STATUS);
  wire hit_b0    = (aw_addr == ADDR_BANK0_BOUND);
  wire hit_b1    = (aw_addr == ADDR_BANK1_BOUND);
  wire wr_mapped = hit_ctrl || hit_rfsh || hit_stat || hit_b0 || hit_b1;

  wire [31:0] next_ctrl  = merge_bytes(ddr_control, w_data, w_strb, CTRL_WRITE_MASK);
  wire [31:0] next_rfsh  = merge_bytes(32'(refresh_count), w_data, w_strb, 32'hFFFF_FFFF);
  wire [31:0] next_bank0 = merge_bytes(bank0_boundary, w_data, w_strb, BOUND_WRITE_MASK);
  wire [31:0] next_bank1 = merge_bytes(bank1_boundary, w_data, w_strb, BOUND_WRITE_MASK);

  wire ctrl_bad  = next_ctrl[CTRL_MEM_TYPE_BIT] &&
                   (next_ctrl[CTRL_WDL_HI:CTRL_WDL_LO] == WDL_DDR1_ONLY);
  wire refuse    = hit_ctrl && ctrl_bad;
  wire [1:0] next_bresp = !wr_mapped ? RESP_DECERR : (refuse ? RESP_SLVERR : RESP_OKAY);

  wire banks_differ = (bank0_boundary != bank1_boundary);

  // read path decode
  wire ar_take = i_s_axi_arvalid && o_s_axi_arready;
  wire [31:0] status_word = {REFRESH_W'(refresh_now), {(32-REFRESH_W-2){1'b0}},
                             write_refused, banks_differ};
  wire rd_mapped = (i_s_axi_araddr == ADDR_DDR_CONTROL) || (i_s_axi_araddr == ADDR_REFRESH_COUNT) ||
                   (i_s_axi_araddr == ADDR_STATUS) || (i_s_axi_araddr == ADDR_BANK0_BOUND) ||
                   (i_s_axi_araddr == ADDR_BANK1_BOUND);
  wire [31:0] next_rdata =
    (i_s_axi_araddr == ADDR_DDR_CONTROL)   ? ddr_control :
    (i_s_axi_araddr == ADDR_REFRESH_COUNT) ? 32'(refresh_count) :
    (i_s_axi_araddr == ADDR_STATUS)        ? status_word :
    (i_s_axi_araddr == ADDR_BANK0_BOUND)   ? bank0_boundary :
    (i_s_axi_araddr == ADDR_BANK1_BOUND)   ? bank1_boundary : 32'h0000_0000;

  // address and data may arrive in either order; each held until the write
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 32'h0000_0000;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
    end else if (i_clk_en) begin
      if (aw_take) begin
        aw_held         <= 1'b1;
        aw_addr         <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held         <= 1'b1;
        w_data         <= i_s_axi_wdata;
        w_strb         <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (do_write) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= next_bresp;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reserved boundary bits are never stored, so they read as zero
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bank0_boundary <= BOUND_RESET;
      bank1_boundary <= BOUND_RESET;
      ddr_control    <= CTRL_RESET;
      refresh_count  <= REFRESH_RESET;
      write_refused  <= 1'b0;
    end else if (i_clk_en && do_write) begin
      if (hit_b0)
        bank0_boundary <= next_bank0;
      if (hit_b1)
        bank1_boundary <= next_bank1;
      if (hit_ctrl && !ctrl_bad)
        ddr_control <= next_ctrl;
      if (hit_rfsh)
        refresh_count <= next_rfsh[REFRESH_W-1:0];
      // last control write outcome, cleared by the next good one
      if (hit_ctrl)
        write_refused <= ctrl_bad;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (ar_take) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid  <= 1'b1;
        o_s_axi_rdata   <= next_rdata;
        o_s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_arready <= 1'b1;
        o_s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // mismatch moves termination to output 1
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_termination_out_0 <= 1'b0;
      o_termination_out_1 <= 1'b0;
    end else if (i_clk_en) begin
      o_termination_out_0 <= i_write_active && !banks_differ;
      o_termination_out_1 <= i_write_active && banks_differ;
    end
  end

  // control outputs held in step with the register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_type_ddr2            <= CTRL_RESET[CTRL_MEM_TYPE_BIT];
      o_write_data_latency_field <= CTRL_RESET[CTRL_WDL_HI:CTRL_WDL_LO];
      o_refresh_req              <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_type_ddr2            <= ddr_control[CTRL_MEM_TYPE_BIT];
      o_write_data_latency_field <= ddr_control[CTRL_WDL_HI:CTRL_WDL_LO];
      o_refresh_req              <= refresh_pulse;
    end
  end

  refresh_timer #(
    .WIDTH (REFRESH_W)
  ) u_refresh_timer (
    .i_sys_clk     (i_sys_clk),
    .i_rst_b       (i_rst_b),
    .i_clk_en      (i_clk_en),
    .i_period      (refresh_count),
    .o_refresh_req (refresh_pulse),
    .o_count       (refresh_now)
  );

  property p_term_exclusive;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !(o_termination_out_0 && o_termination_out_1);
  endproperty
  a_term_exclusive: assert property (p_term_exclusive) else $error("both terminations on");

  property p_term_on_write;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && i_write_active) |=> (o_termination_out_0 || o_termination_out_1);
  endproperty
  a_term_on_write: assert property (p_term_on_write) else $error("no termination during write");

  property p_equal_uses_out0;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && i_write_active && bank0_boundary == bank1_boundary) |=> o_termination_out_0;
  endproperty
  a_equal_uses_out0: assert property (p_equal_uses_out0) else $error("equal banks not on output 0");

  property p_top_bits_out1;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && i_write_active &&
     bank0_boundary[BOUND_TOP_HI:BOUND_TOP_LO] != bank1_boundary[BOUND_TOP_HI:BOUND_TOP_LO])
    |=> (o_termination_out_1 && !o_termination_out_0);
  endproperty
  a_top_bits_out1: assert property (p_top_bits_out1) else $error("top bit mismatch not on output 1");

  property p_latency_refused;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && do_write && refuse) |=> (o_s_axi_bvalid && o_s_axi_bresp == RESP_SLVERR &&
                                          ddr_control == $past(ddr_control));
  endproperty
  a_latency_refused: assert property (p_latency_refused) else $error("ddr-ii latency zero accepted");

  property p_latency_never_out;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !(o_mem_type_ddr2 && o_write_data_latency_field == WDL_DDR1_ONLY);
  endproperty
  a_latency_never_out: assert property (p_latency_never_out) else $error("ddr-ii with latency zero");

endmodule : ddr_bank_term

`default_nettype wire

// File: src/ddr_term_pkg.sv
/*
  Shared constants for the bank boundary, termination select and refresh
  logic of the DDR controller: register byte addresses, field layout,
  reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package ddr_term_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_DDR_CONTROL   = 32'hFFFF_E500;
  localparam logic [31:0] ADDR_REFRESH_COUNT = 32'hFFFF_E504;
  localparam logic [31:0] ADDR_STATUS        = 32'hFFFF_E508;
  localparam logic [31:0] ADDR_BANK0_BOUND   = 32'hFFFF_E510;
  localparam logic [31:0] ADDR_BANK1_BOUND   = 32'hFFFF_E514;

  // boundary registers: low field 6:0 and top field 31:30 are storage
  localparam logic [31:0] BOUND_WRITE_MASK   = 32'hC000_007F;
  localparam logic [31:0] BOUND_RESET        = 32'h0000_0000;
  localparam int          BOUND_TOP_HI       = 31;
  localparam int          BOUND_TOP_LO       = 30;

  // ddr control register
  localparam int          CTRL_MEM_TYPE_BIT  = 0;
  localparam int          CTRL_WDL_HI        = 13;
  localparam int          CTRL_WDL_LO        = 12;
  localparam logic [31:0] CTRL_WRITE_MASK    = 32'h0000_3001;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
  localparam logic [1:0]  WDL_DDR1_ONLY      = 2'h0;

  // refresh count register
  localparam int          REFRESH_WIDTH      = 16;
  localparam logic [15:0] REFRESH_RESET      = 16'h0000;
  localparam logic [15:0] REFRESH_333_7US8   = 16'h0500;
  localparam logic [15:0] REFRESH_333_15US6  = 16'h0A00;
  localparam logic [15:0] REFRESH_400_7US8   = 16'h0600;
  localparam logic [15:0] REFRESH_400_15US6  = 16'h0C00;

  // status register
  localparam int          STAT_SELECT_BIT    = 0;
  localparam int          STAT_REFUSED_BIT   = 1;
  localparam int          STAT_COUNT_LO      = 16;

  // bus responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
  localparam logic [1:0]  RESP_DECERR        = 2'h3;

endpackage : ddr_term_pkg

// File: src/refresh_timer.sv
/*
  Refresh interval timer: counts memory clock cycles and pulses one
  refresh request each time the programmed count elapses.
  Assumes the count comes from a register on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module refresh_timer
  import ddr_term_pkg::*;
#(
  parameter int WIDTH = REFRESH_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_period,
  output logic                  o_refresh_req,
  output logic      [WIDTH-1:0] o_count
);

  wire             timer_on = (i_period != '0);
  wire             expired  = (o_count == '0);
  wire [WIDTH-1:0] reload   = WIDTH'(i_period - WIDTH'(1));

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count       <= '0;
      o_refresh_req <= 1'b0;
    end else if (i_clk_en) begin
      o_refresh_req <= timer_on && expired;
      if (!timer_on)
        o_count <= '0;
      else if (expired)
        o_count <= reload;
      else
        o_count <= WIDTH'(o_count - WIDTH'(1));
    end
  end

  property p_refresh_gap;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && o_refresh_req && i_period > WIDTH'(1)) |=> !o_refresh_req;
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh requests too close");

  property p_refresh_reload;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && timer_on && expired) |=> (o_refresh_req && o_count == $past(reload));
  endproperty
  a_refresh_reload: assert property (p_refresh_reload) else $error("refresh timer did not reload");

endmodule : refresh_timer

`default_nettype wire

// File: tb/dimm_model.sv
/*
  Memory module observer: counts refresh requests, measures the gap
  between them and counts cycles with both ranks terminating.
  Assumes the controller outputs share its clock.
*/
`timescale 1ns/100ps
`default_nettype none

module dimm_model (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  input  wire logic   i_termination_out_0,
  input  wire logic   i_termination_out_1,
  input  wire logic   i_refresh_req,
  output logic [31:0] o_refresh_seen,
  output logic [31:0] o_last_gap,
  output logic [31:0] o_both_on
);
  logic [31:0] gap;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gap            <= 32'h0;
      o_refresh_seen <= 32'h0;
      o_last_gap     <= 32'h0;
      o_both_on      <= 32'h0;
    end else begin
      gap <= i_refresh_req ? 32'h1 : gap + 32'h1;
      if (i_refresh_req) begin
        o_refresh_seen <= o_refresh_seen + 32'h1;
        o_last_gap     <= gap;
      end
      if (i_termination_out_0 && i_termination_out_1) o_both_on <= o_both_on + 32'h1;
    end
  end
endmodule : dimm_model

`default_nettype wire

// File: tb/ddr_bank_boundary_termination_bench.sv
/*
  Self-checking bench for the bank boundary termination block.
  Assumes an AXI4-Lite master in this module and the module observer.
*/
`timescale 1ns/100ps
`default_nettype none

module ddr_bank_boundary_termination_bench;
  import ddr_term_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        clk_en  = 1'b1;
  logic        wr_act  = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [31:0] araddr  = 32'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        term0;
  logic        term1;
  logic        ddr2;
  logic [1:0]  wdl;
  logic        refresh;
  logic [31:0] seen;
  logic [31:0] gap;
  logic [31:0] both;
  logic [31:0] d;
  logic [31:0] exp_ctrl = 32'h0;
  logic [15:0] rv [4] = '{16'h0500, 16'h0A00, 16'h0600, 16'h0C00};
  logic        bad;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n;

  always #12.5 sys_clk = ~sys_clk;

  ddr_bank_term dut_u (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_write_active(wr_act),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_termination_out_0(term0), .o_termination_out_1(term1), .o_mem_type_ddr2(ddr2),
    .o_write_data_latency_field(wdl), .o_refresh_req(refresh));

  dimm_model dimm_u (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_termination_out_0(term0),
    .i_termination_out_1(term1), .i_refresh_req(refresh),
    .o_refresh_seen(seen), .o_last_gap(gap), .o_both_on(both));

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // bounded wait; the final check also flags a missing response
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    k = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] v, input logic [1:0] er);
    int k;
    k = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    v = rdata;
    rready <= 1'b0;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    @(posedge sys_clk);
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    rd(a, v, er);
    chk(v, e);
  endtask : rdc

  // outputs lag write_active by one enabled edge
  task automatic term(input logic wa, input logic e0, input logic e1);
    wr_act <= wa;
    repeat (2) @(posedge sys_clk);
    chk({30'h0, term0, term1}, {30'h0, e0, e1});
  endtask : term

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdc(ADDR_BANK0_BOUND, 32'h0, RESP_OKAY);
    rdc(ADDR_BANK1_BOUND, 32'h0, RESP_OKAY);
    rdc(ADDR_DDR_CONTROL, 32'h0, RESP_OKAY);
    // bank 1 first, so its low field is never zero beside a nonzero bank 0
    wr(ADDR_BANK1_BOUND, 32'h4000_0012, RESP_OKAY);
    // only the defined fields are written, reserved bits stay clear
    wr(ADDR_BANK0_BOUND, 32'hC000_007F, RESP_OKAY);
    rdc(ADDR_BANK0_BOUND, 32'hC000_007F, RESP_OKAY);
    wr(ADDR_BANK0_BOUND, 32'h4000_0012, RESP_OKAY);
    wr(ADDR_BANK1_BOUND, 32'h4000_0012, RESP_OKAY);
    term(1'b1, 1'b1, 1'b0);
    wr(ADDR_BANK1_BOUND, 32'h8000_0012, RESP_OKAY);
    term(1'b1, 1'b0, 1'b1);
    wr(ADDR_BANK1_BOUND, 32'h4000_0013, RESP_OKAY);
    term(1'b1, 1'b0, 1'b1);
    term(1'b0, 1'b0, 1'b0);
    clk_en <= 1'b0;
    term(1'b1, 1'b0, 1'b0);
    clk_en <= 1'b1;
    term(1'b1, 1'b0, 1'b1);
    rd(ADDR_STATUS, d, RESP_OKAY);
    chk({31'h0, d[0]}, 32'h1);
    // status is read-only: a write is accepted and changes nothing
    wr(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, d, RESP_OKAY);
    chk({31'h0, d[0]}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      for (int l = 0; l < 4; l++) begin
        d   = {18'h0, l[1:0], 11'h0, m[0]};
        bad = (m == 1 && l == 0);
        wr(ADDR_DDR_CONTROL, d, bad ? RESP_SLVERR : RESP_OKAY);
        if (!bad) exp_ctrl = d;
        rdc(ADDR_DDR_CONTROL, exp_ctrl, RESP_OKAY);
        rd(ADDR_STATUS, d, RESP_OKAY);
        chk({31'h0, d[1]}, {31'h0, bad});
        chk({29'h0, ddr2, wdl}, {29'h0, exp_ctrl[0], exp_ctrl[13:12]});
      end
    end
    wr(32'hFFFF_E50C, 32'h1234_5678, RESP_DECERR);
    rdc(32'hFFFF_E50C, 32'h0, RESP_DECERR);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_REFRESH_COUNT, {16'h0, rv[i]}, RESP_OKAY);
      rdc(ADDR_REFRESH_COUNT, {16'h0, rv[i]}, RESP_OKAY);
      d = seen;
      n = 0;
      while (seen < d + 32'h3 && n < 4 * int'(rv[i]) + 100) begin
        @(posedge sys_clk);
        n++;
      end
      chk(gap, {16'h0, rv[i]});
      rd(ADDR_STATUS, d, RESP_OKAY);
      chk({31'h0, d[31:16] < rv[i]}, 32'h1);
    end
    wr(ADDR_REFRESH_COUNT, 32'h0, RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    d = seen;
    repeat (4000) @(posedge sys_clk);
    chk(seen, d);
    rd(ADDR_STATUS, d, RESP_OKAY);
    chk({16'h0, d[31:16]}, 32'h0);
    chk(both, 32'h0);
    tally_and_finish();
  end

  // about twice the expected run
  initial begin
    #1500000;
    num_errors++;
    tally_and_finish();
  end
endmodule : ddr_bank_boundary_termination_bench

`default_nettype wire
